// file: verilog/hdp_pkg.sv
// shared constants for the hold-mode dram host port
package hdp_pkg;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int WORD_W = 32;
   localparam int LINE_W = 128;
   localparam int OFS_W = 3;
   localparam int FIFO_DEPTH = 32;
   localparam int MEM_LINES = 64;
   localparam int CLK_PERIOD_NS = 100;
   // internal dram line access, must land in 3..7 periods
   localparam int DRAM_ACCESS_NS = 400;
   localparam int DRAM_CYC = (DRAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // peripheral answer delay to a device bus cycle
   localparam int PERIPH_CYC = 2;
   localparam logic PIN_IDLE = 1'b1;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
endpackage

// file: verilog/hdp_link_if.sv
// system bus between device and external master
`timescale 1ns/10ps
`default_nettype none
interface hdp_link_if;
   // device drives
   logic [22:0] dev_addr;
   logic [15:0] dev_data;
   logic dev_rw, dev_ubs_n, dev_lbs_n, dev_bus_start_n, dev_burst_n, dev_bus_oe;
   logic dev_data_oe, dev_dc_n, dev_dc_oe, hold_grant_n;
   // external master drives
   logic [22:0] host_addr;
   logic [15:0] host_data;
   logic host_rw, host_ubs_n, host_lbs_n, space_select_n, host_bus_oe;
   logic host_data_oe, host_dc_n, host_dc_oe, cs_n, hold_request_n;
   // resolved wire levels, pulled high when nobody drives
   logic [22:0] addr;
   logic [15:0] data;
   logic rw, ubs_n, lbs_n, dc_n;
   assign addr = dev_bus_oe ? dev_addr : (host_bus_oe ? host_addr : '1);
   // device owns data in its own write cycles and on reads in hold
   assign data = (dev_data_oe || (dev_bus_oe && !dev_rw)) ? dev_data : (host_data_oe ? host_data : '1);
   assign rw = dev_bus_oe ? dev_rw : (host_bus_oe ? host_rw : 1'b1);
   assign ubs_n = dev_bus_oe ? dev_ubs_n : (host_bus_oe ? host_ubs_n : 1'b1);
   assign lbs_n = dev_bus_oe ? dev_lbs_n : (host_bus_oe ? host_lbs_n : 1'b1);
   assign dc_n = dev_dc_oe ? dev_dc_n : (host_dc_oe ? host_dc_n : 1'b1);
   modport dev (
      output dev_addr, dev_data, dev_rw, dev_ubs_n, dev_lbs_n, dev_bus_start_n, dev_burst_n,
      output dev_bus_oe, dev_data_oe, dev_dc_n, dev_dc_oe, hold_grant_n,
      input addr, data, rw, ubs_n, lbs_n, dc_n, cs_n, hold_request_n, space_select_n
   );
   modport host (
      output host_addr, host_data, host_rw, host_ubs_n, host_lbs_n, space_select_n,
      output host_bus_oe, host_data_oe, host_dc_n, host_dc_oe, cs_n, hold_request_n,
      input addr, data, rw, dc_n, hold_grant_n, dev_bus_start_n, dev_burst_n
   );
endinterface
`default_nettype wire

// file: verilog/hdp_fifo.sv
// word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module hdp_fifo #(
   parameter int W = 55,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, rd_ptr_r;
   logic [AW:0] count_r;
   logic push, pop;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: verilog/hdp_device.sv
// device end: burst writer, hold arbiter and external dram access
`timescale 1ns/10ps
`default_nettype none
module hdp_device #(
   parameter int MEM_LINES = hdp_pkg::MEM_LINES,
   parameter int DRAM_CYC = hdp_pkg::DRAM_CYC,
   parameter int FIFO_DEPTH = hdp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // cpu word writes to the external bus
   input wire logic cpu_valid,
   output logic cpu_ready,
   input wire logic [hdp_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [hdp_pkg::WORD_W-1:0] cpu_data,
   // status
   output logic in_hold,
   // system bus
   hdp_link_if.dev bus
);
   localparam int LW = $clog2(MEM_LINES);
   localparam int FW = hdp_pkg::ADDR_W + hdp_pkg::WORD_W;
   typedef enum logic [2:0] {N_IDLE, N_UPPER, N_LOWER, H_IDLE, H_DRAM, H_RETRY, H_FLUSH} hdp_state_t;

   hdp_state_t state_r;
   logic [hdp_pkg::LINE_W-1:0] dram [MEM_LINES];
   logic [hdp_pkg::LINE_W-1:0] line_r;
   logic [LW-1:0] tag_r;
   logic line_valid_r, dirty_r;
   logic [3:0] dram_cnt_r;
   logic [hdp_pkg::WORD_W-1:0] word_r;
   logic [hdp_pkg::ADDR_W-1:0] word_addr_r;
   logic dc_wait_r;
   logic f_valid, f_pop;
   logic [FW-1:0] f_data;

   // two-flop synchronisers for everything the master drives except space_select_n
   logic [hdp_pkg::ADDR_W-1:0] addr_s1, addr_s2;
   logic [hdp_pkg::DATA_W-1:0] data_s1, data_s2;
   logic [5:0] ctl_s1, ctl_s2;
   logic cs_prev_r;
   logic rw_s, ubs_s, lbs_s, dc_s, cs_s, hold_request_s, cs_fall, hit, acc_done;
   logic [LW-1:0] req_line;
   logic [hdp_pkg::OFS_W-1:0] req_ofs;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         addr_s1 <= hdp_pkg::ADDR_RST;
         addr_s2 <= hdp_pkg::ADDR_RST;
         data_s1 <= hdp_pkg::DATA_RST;
         data_s2 <= hdp_pkg::DATA_RST;
         ctl_s1 <= '1;
         ctl_s2 <= '1;
         cs_prev_r <= hdp_pkg::PIN_IDLE;
      end
      else
      begin
         addr_s1 <= bus.addr;
         addr_s2 <= addr_s1;
         data_s1 <= bus.data;
         data_s2 <= data_s1;
         ctl_s1 <= {bus.rw, bus.ubs_n, bus.lbs_n, bus.dc_n, bus.cs_n, bus.hold_request_n};
         ctl_s2 <= ctl_s1;
         cs_prev_r <= ctl_s2[1];
      end
   end

   assign {rw_s, ubs_s, lbs_s, dc_s, cs_s, hold_request_s} = ctl_s2;
   assign cs_fall = cs_prev_r && !cs_s;
   assign req_line = addr_s2[hdp_pkg::OFS_W +: LW];
   assign req_ofs = addr_s2[hdp_pkg::OFS_W-1:0];
   assign hit = line_valid_r && (tag_r == req_line);
   assign acc_done = (state_r == H_IDLE && cs_fall && hit) || state_r == H_RETRY;
   assign f_pop = (state_r == N_IDLE) && hold_request_s && f_valid;

   hdp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(cpu_valid),
      .in_ready(cpu_ready),
      .in_data({cpu_addr, cpu_data}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // halfword 0 sits at the msb end of the line, matching the big-endian pins
   function automatic logic [hdp_pkg::DATA_W-1:0] get_hw(
      input logic [hdp_pkg::LINE_W-1:0] line, input logic [hdp_pkg::OFS_W-1:0] ofs);
      get_hw = line[(~ofs)*hdp_pkg::DATA_W +: hdp_pkg::DATA_W];
   endfunction

   // upper strobe owns data[15:8] (pins D0-D7), lower owns data[7:0]
   function automatic logic [hdp_pkg::LINE_W-1:0] put_hw(
      input logic [hdp_pkg::LINE_W-1:0] line, input logic [hdp_pkg::OFS_W-1:0] ofs,
      input logic [hdp_pkg::DATA_W-1:0] d, input logic ub_n, input logic lb_n);
      logic [hdp_pkg::LINE_W-1:0] l;
      l = line;
      if (!ub_n)
         l[(~ofs)*hdp_pkg::DATA_W + 8 +: 8] = d[15:8];
      if (!lb_n)
         l[(~ofs)*hdp_pkg::DATA_W +: 8] = d[7:0];
      put_hw = l;
   endfunction

   // main sequencer
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= N_IDLE;
         dram_cnt_r <= '0;
         word_r <= '0;
         word_addr_r <= hdp_pkg::ADDR_RST;
         dc_wait_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            N_IDLE:
               if (!hold_request_s)
                  state_r <= H_IDLE;
               else if (f_valid)
               begin
                  {word_addr_r, word_r} <= f_data;
                  dc_wait_r <= 1'b0;
                  state_r <= N_UPPER;
               end
            N_UPPER:
               if (!dc_s && dc_wait_r)
               begin
                  dc_wait_r <= 1'b0;
                  state_r <= N_LOWER;
               end
               else
                  dc_wait_r <= 1'b1;
            N_LOWER:
               if (!dc_s && dc_wait_r)
                  state_r <= N_IDLE;
               else
                  dc_wait_r <= 1'b1;
            H_IDLE:
               if (cs_fall && !hit)
               begin
                  dram_cnt_r <= 4'(DRAM_CYC - 1);
                  state_r <= H_DRAM;
               end
               else if (hold_request_s && cs_s)
               begin
                  // never leave hold with unsaved writes
                  dram_cnt_r <= 4'(DRAM_CYC - 1);
                  state_r <= dirty_r ? H_FLUSH : N_IDLE;
               end
            H_DRAM:
               if (dram_cnt_r == '0)
                  state_r <= H_RETRY;
               else
                  dram_cnt_r <= dram_cnt_r - 1'b1;
            H_RETRY:
               state_r <= H_IDLE;
            H_FLUSH:
               if (dram_cnt_r == '0)
                  state_r <= N_IDLE;
               else
                  dram_cnt_r <= dram_cnt_r - 1'b1;
            default:
               state_r <= N_IDLE;
         endcase
      end
   end

   // line buffer and dram array
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         line_r <= '0;
         tag_r <= '0;
         line_valid_r <= 1'b0;
         dirty_r <= 1'b0;
      end
      else if ((state_r == H_DRAM || state_r == H_FLUSH) && dram_cnt_r == '0)
      begin
         if (dirty_r)
            dram[tag_r] <= line_r;
         dirty_r <= 1'b0;
         if (state_r == H_DRAM)
         begin
            line_r <= dram[req_line];
            tag_r <= req_line;
            line_valid_r <= 1'b1;
         end
      end
      else if (((state_r == H_IDLE && cs_fall && hit) || state_r == H_RETRY) && !rw_s)
      begin
         line_r <= put_hw(line_r, req_ofs, data_s2, ubs_s, lbs_s);
         dirty_r <= 1'b1;
      end
   end

   // bus pins
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus.dev_addr <= hdp_pkg::ADDR_RST;
         bus.dev_data <= hdp_pkg::DATA_RST;
         bus.dev_rw <= hdp_pkg::PIN_IDLE;
         bus.dev_ubs_n <= hdp_pkg::PIN_IDLE;
         bus.dev_lbs_n <= hdp_pkg::PIN_IDLE;
         bus.dev_bus_start_n <= hdp_pkg::PIN_IDLE;
         bus.dev_burst_n <= hdp_pkg::PIN_IDLE;
         bus.dev_bus_oe <= 1'b0;
         bus.hold_grant_n <= hdp_pkg::PIN_IDLE;
         in_hold <= 1'b0;
      end
      else
      begin
         bus.dev_bus_start_n <= hdp_pkg::PIN_IDLE;
         case (state_r)
            N_IDLE:
            begin
               bus.dev_bus_oe <= hold_request_s;
               bus.hold_grant_n <= hold_request_s;
               in_hold <= !hold_request_s;
               bus.dev_rw <= hdp_pkg::PIN_IDLE;
               bus.dev_ubs_n <= hdp_pkg::PIN_IDLE;
               bus.dev_lbs_n <= hdp_pkg::PIN_IDLE;
               if (hold_request_s && f_valid)
               begin
                  bus.dev_addr <= {f_data[FW-1:hdp_pkg::WORD_W+1], 1'b0};
                  bus.dev_data <= f_data[hdp_pkg::WORD_W-1:hdp_pkg::DATA_W];
                  bus.dev_rw <= 1'b0;
                  bus.dev_ubs_n <= 1'b0;
                  bus.dev_lbs_n <= 1'b0;
                  bus.dev_bus_start_n <= 1'b0;
                  bus.dev_burst_n <= 1'b0;
               end
            end
            N_UPPER:
               if (!dc_s && dc_wait_r)
               begin
                  bus.dev_addr <= {word_addr_r[hdp_pkg::ADDR_W-1:1], 1'b1};
                  bus.dev_data <= word_r[hdp_pkg::DATA_W-1:0];
                  bus.dev_bus_start_n <= 1'b0;
                  bus.dev_burst_n <= hdp_pkg::PIN_IDLE;
               end
            H_IDLE, H_DRAM, H_RETRY, H_FLUSH:
            begin
               bus.dev_bus_oe <= 1'b0;
               bus.hold_grant_n <= 1'b0;
               in_hold <= 1'b1;
               if (acc_done && rw_s)
                  bus.dev_data <= get_hw(line_r, req_ofs);
            end
            default:
               bus.dev_burst_n <= hdp_pkg::PIN_IDLE;
         endcase
      end
   end

   // data and data-complete toward the master in hold
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus.dev_data_oe <= 1'b0;
         bus.dev_dc_oe <= 1'b0;
         bus.dev_dc_n <= hdp_pkg::PIN_IDLE;
      end
      else
      begin
         bus.dev_dc_oe <= in_hold && !cs_s;
         bus.dev_data_oe <= in_hold && !cs_s && rw_s;
         bus.dev_dc_n <= !acc_done;
      end
   end
endmodule
`default_nettype wire

// file: verilog/hdp_host.sv
// external master end: hold requester, dram accessor, burst peripheral
`timescale 1ns/10ps
`default_nettype none
module hdp_host (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // hold control
   input wire logic want_hold,
   output logic hold_granted,
   // dram access commands, taken only while granted
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [hdp_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [hdp_pkg::DATA_W-1:0] cmd_wdata,
   input wire logic cmd_ubs_n,
   input wire logic cmd_lbs_n,
   output logic rsp_valid,
   output logic [hdp_pkg::DATA_W-1:0] rsp_rdata,
   // halfwords received from device bus cycles
   output logic per_valid,
   output logic [hdp_pkg::ADDR_W-1:0] per_addr,
   output logic [hdp_pkg::DATA_W-1:0] per_data,
   // system bus
   hdp_link_if.host bus
);
   typedef enum logic [1:0] {M_IDLE, M_ACCESS, M_GAP} hdp_mst_t;
   hdp_mst_t mst_r;
   logic [hdp_pkg::ADDR_W-1:0] addr_s1, addr_s2;
   logic [hdp_pkg::DATA_W-1:0] data_s1, data_s2;
   logic [3:0] ctl_s1, ctl_s2;
   logic dc_s, grant_s, bs_s, rw_s;
   logic [1:0] per_cnt_r;
   logic per_busy_r;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         addr_s1 <= hdp_pkg::ADDR_RST;
         addr_s2 <= hdp_pkg::ADDR_RST;
         data_s1 <= hdp_pkg::DATA_RST;
         data_s2 <= hdp_pkg::DATA_RST;
         ctl_s1 <= '1;
         ctl_s2 <= '1;
      end
      else
      begin
         addr_s1 <= bus.addr;
         addr_s2 <= addr_s1;
         data_s1 <= bus.data;
         data_s2 <= data_s1;
         ctl_s1 <= {bus.dc_n, bus.hold_grant_n, bus.dev_bus_start_n, bus.rw};
         ctl_s2 <= ctl_s1;
      end
   end
   assign {dc_s, grant_s, bs_s, rw_s} = ctl_s2;

   // dram accessor; one access per chip-select pulse, gap after each
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mst_r <= M_IDLE;
         bus.cs_n <= hdp_pkg::PIN_IDLE;
         bus.hold_request_n <= hdp_pkg::PIN_IDLE;
         bus.host_addr <= hdp_pkg::ADDR_RST;
         bus.host_data <= hdp_pkg::DATA_RST;
         bus.host_rw <= hdp_pkg::PIN_IDLE;
         bus.host_ubs_n <= hdp_pkg::PIN_IDLE;
         bus.host_lbs_n <= hdp_pkg::PIN_IDLE;
         bus.space_select_n <= hdp_pkg::PIN_IDLE;
         bus.host_bus_oe <= 1'b0;
         bus.host_data_oe <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= hdp_pkg::DATA_RST;
         hold_granted <= 1'b0;
      end
      else
      begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         hold_granted <= !grant_s;
         bus.host_bus_oe <= !grant_s;
         bus.space_select_n <= grant_s;
         case (mst_r)
            M_IDLE:
            begin
               // only released from idle, so select is already high
               bus.hold_request_n <= !want_hold;
               bus.host_data_oe <= 1'b0;
               if (!grant_s && want_hold && cmd_valid && !cmd_ready)
               begin
                  bus.host_addr <= cmd_addr;
                  bus.host_data <= cmd_wdata;
                  bus.host_rw <= !cmd_write;
                  bus.host_ubs_n <= cmd_ubs_n;
                  bus.host_lbs_n <= cmd_lbs_n;
                  bus.host_data_oe <= cmd_write;
                  bus.cs_n <= 1'b0;
                  cmd_ready <= 1'b1;
                  mst_r <= M_ACCESS;
               end
            end
            M_ACCESS:
               if (!dc_s)
               begin
                  bus.cs_n <= hdp_pkg::PIN_IDLE;
                  rsp_valid <= bus.host_rw;
                  rsp_rdata <= data_s2;
                  mst_r <= M_GAP;
               end
            M_GAP:
            begin
               // select stays high here before any direction change
               bus.host_data_oe <= 1'b0;
               mst_r <= M_IDLE;
            end
            default:
               mst_r <= M_IDLE;
         endcase
      end
   end

   // peripheral: answers each device bus start with data complete
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         per_cnt_r <= '0;
         per_busy_r <= 1'b0;
         per_valid <= 1'b0;
         per_addr <= hdp_pkg::ADDR_RST;
         per_data <= hdp_pkg::DATA_RST;
         bus.host_dc_n <= hdp_pkg::PIN_IDLE;
         bus.host_dc_oe <= 1'b0;
      end
      else
      begin
         per_valid <= 1'b0;
         bus.host_dc_n <= hdp_pkg::PIN_IDLE;
         bus.host_dc_oe <= grant_s;
         if (grant_s && !bs_s && !per_busy_r)
         begin
            per_busy_r <= 1'b1;
            per_cnt_r <= 2'(hdp_pkg::PERIPH_CYC - 1);
            per_addr <= addr_s2;
            per_data <= data_s2;
            per_valid <= !rw_s;
         end
         else if (per_busy_r)
         begin
            if (per_cnt_r == '0)
            begin
               bus.host_dc_n <= 1'b0;
               per_busy_r <= 1'b0;
            end
            else
               per_cnt_r <= per_cnt_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/hdp_device_note.sv
// no logic here: the device end lives in hdp_device.sv

// file: testbench/hdp_link_chk.sv
// bus assertions between device and master ends
`timescale 1ns/10ps
`default_nettype none
module hdp_link_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // device side
   input wire logic [22:0] dev_addr,
   input wire logic dev_rw,
   input wire logic dev_bus_start_n,
   input wire logic dev_burst_n,
   input wire logic dev_bus_oe,
   input wire logic dev_data_oe,
   input wire logic dev_dc_n,
   input wire logic dev_dc_oe,
   input wire logic hold_grant_n,
   // master side
   input wire logic cs_n,
   input wire logic hold_request_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence upper_cyc;
      !dev_bus_start_n && !dev_burst_n;
   endsequence
   sequence lower_cyc;
      !dev_bus_start_n && dev_burst_n;
   endsequence
   a_upper_even_write: assert property (upper_cyc |-> !dev_addr[0] && !dev_rw && dev_bus_oe)
      else $error("upper burst cycle wrong");
   a_lower_odd_write: assert property (lower_cyc |-> dev_addr[0] && !dev_rw && dev_bus_oe)
      else $error("lower burst cycle wrong");
   a_burst_pair_ends: assert property (upper_cyc |-> ##[1:60] lower_cyc)
      else $error("burst has no lower cycle");
   a_burst_with_start: assert property ($fell(dev_burst_n) |-> !dev_bus_start_n)
      else $error("burst low outside first cycle");
   a_grant_after_req: assert property ($fell(hold_grant_n) |-> !hold_request_n)
      else $error("grant without request");
   a_hold_floats_bus: assert property (!hold_grant_n |-> !dev_bus_oe)
      else $error("bus driven in hold");
   a_drive_only_hold: assert property (dev_data_oe || dev_dc_oe |-> !hold_grant_n)
      else $error("data or complete driven outside hold");
   a_access_completes: assert property ($fell(cs_n) && !hold_grant_n |-> ##[2:24] !dev_dc_n && dev_dc_oe)
      else $error("access never completed");
   a_leave_needs_release: assert property ($rose(hold_grant_n) |-> hold_request_n && cs_n)
      else $error("hold left while requested");
endmodule
`default_nettype wire

// file: testbench/test_hold_mode_dram_host_port.sv
// self-checking bench for the hold-mode dram host port
`timescale 1ns/10ps
`default_nettype none
module test_hold_mode_dram_host_port;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cpu_valid = 1'b0;
   logic want_hold = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic cmd_ubs_n = 1'b1;
   logic cmd_lbs_n = 1'b1;
   logic [22:0] cpu_addr = '0;
   logic [22:0] cmd_addr = '0;
   logic [31:0] cpu_data = '0;
   logic [15:0] cmd_wdata = '0;
   logic cpu_ready, in_hold, hold_granted, cmd_ready, rsp_valid, per_valid;
   logic [22:0] per_addr;
   logic [15:0] rsp_rdata, per_data;
   logic [15:0] mem [int];
   logic [38:0] per_q [$];
   int n_errors = 0;
   int checks = 0;
   int seed = 32'h613f;
   int full_seen = 0;
   int i, la, lb, lat, lat0;
   always #50 sys_clk = ~sys_clk;
   hdp_link_if link ();
   hdp_device hdp_device_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_valid(cpu_valid),
      .cpu_ready(cpu_ready), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .in_hold(in_hold), .bus(link));
   hdp_host hdp_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .want_hold(want_hold),
      .hold_granted(hold_granted), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ubs_n(cmd_ubs_n), .cmd_lbs_n(cmd_lbs_n),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .per_valid(per_valid), .per_addr(per_addr),
      .per_data(per_data), .bus(link));
   hdp_link_chk hdp_link_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .dev_addr(link.dev_addr),
      .dev_rw(link.dev_rw), .dev_bus_start_n(link.dev_bus_start_n), .dev_burst_n(link.dev_burst_n),
      .dev_bus_oe(link.dev_bus_oe), .dev_data_oe(link.dev_data_oe), .dev_dc_n(link.dev_dc_n),
      .dev_dc_oe(link.dev_dc_oe), .hold_grant_n(link.hold_grant_n), .cs_n(link.cs_n),
      .hold_request_n(link.hold_request_n));
   task automatic chk(input string what, input logic [38:0] got, input logic [38:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // upper strobe owns the high byte of the halfword
   function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d, input logic [1:0] bs);
      merge = {bs[1] ? o[15:8] : d[15:8], bs[0] ? o[7:0] : d[7:0]};
   endfunction
   always @(negedge sys_clk)
   begin
      if (per_valid === 1'b1)
         chk("bus halfword", {per_addr, per_data}, per_q.size() > 0 ? per_q.pop_front() : 'x);
   end
   // valid stays up between words so back-to-back offers hit the fifo
   task automatic word(input logic [22:0] a, input logic [31:0] d);
      cpu_valid = 1'b1;
      cpu_addr = a;
      cpu_data = d;
      per_q.push_back({a, d[31:16]});
      per_q.push_back({a | 23'h1, d[15:0]});
      while (cpu_ready !== 1'b1)
      begin
         full_seen++;
         @(negedge sys_clk);
      end
      @(negedge sys_clk);
   endtask
   task automatic cmd(input logic wr, input int a, input logic [15:0] d, input logic [1:0] bs);
      int n;
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = 23'(a);
      cmd_wdata = d;
      {cmd_ubs_n, cmd_lbs_n} = bs;
      for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
         @(negedge sys_clk);
      cmd_valid = 1'b0;
      if (wr)
         mem[a] = merge(mem.exists(a) ? mem[a] : 16'h0000, d, bs);
      else
      begin
         for (lat = 0; lat < 200 && rsp_valid !== 1'b1; lat++)
            @(negedge sys_clk);
         chk("read halfword", rsp_rdata, mem[a]);
      end
   endtask
   task automatic hold(input logic on);
      @(negedge sys_clk);
      want_hold = on;
      for (i = 0; i < 300 && in_hold !== on; i++)
         @(negedge sys_clk);
      chk("in hold", in_hold, on);
      chk("bus enable", link.dev_bus_oe, !on);
   endtask
   initial
   begin
      #2000000;
      n_errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      word(23'h000000, 32'hffff0000);
      word(23'h7ffffe, 32'h0000ffff);
      for (i = 0; i < 40; i++)
         word(23'($random(seed)) & 23'h7ffffe, $random(seed));
      cpu_valid = 1'b0;
      for (i = 0; i < 3000 && per_q.size() > 0; i++)
         @(negedge sys_clk);
      chk("bursts drained", per_q.size(), 0);
      chk("fifo refused", full_seen > 0, 1);
      $display("test bursts done");
      la = ({$random(seed)} % 64) * 8;
      lb = la ^ 8;
      hold(1'b1);
      for (i = 0; i < 16; i++)
         cmd(1'b1, i < 8 ? la + i : lb + i - 8, $random(seed), 2'b00);
      for (i = 1; i < 4; i++)
         cmd(1'b1, lb + i, $random(seed), 2'(i));
      hold(1'b0);
      hold(1'b1);
      for (i = 0; i < 8; i++)
      begin
         cmd(1'b0, lb + i, 16'h0000, 2'b00);
         cmd(1'b0, la + i, 16'h0000, 2'b00);
         if (i == 0)
            lat0 = lat;
      end
      cmd(1'b0, la + 1, 16'h0000, 2'b00);
      chk("hit saving", lat0 - lat, hdp_pkg::DRAM_CYC + 1);
      hold(1'b0);
      $display("test hold access done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
